// >>> rtl/bcpt_top.sv
`timescale 1ns/100ps
// Function
// - comparators off in and during debug accesses
// - range match inside or outside selectable
// - comparator match drives sequencer transition
// - direction enable requires matching direction, ignored in range mode
// - size qualification only on first two
// - tagged match fires at execution stage
// - tagging ignores direction, size and data
// - untagged match fires on bus address
// - match condition never re-checked later
// - match outputs map to comparators directly; in range mode the first carries the range, the second stays low
// - single mode needs exact address equality
// - third comparator: address and direction only
// - third comparator ignores overlapping word access
// - compressed line: code plus three fields
// - code zero base, else increment count
// - new base when upper bits change
// - increments relative to block base
// - first line always base, also rollover
// - pointer shows oldest entry after rollover
// - high field low bit holds bit sixteen
module bcpt_top
  import bcpt_pkg::*;
#(
  parameter int TRACE_DEPTH = TRACE_DEPTH_DEF
) (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // cpu side
  input  wire bcpt_cpu_t   CPU_BUS,
  input  wire bcpt_exec_t  CPU_EXEC,
  input  wire logic        BACKGROUND_DEBUG_MODE,
  input  wire logic        BDM_ACCESS,
  // sequencer
  output logic [2:0]       MATCH,
  // axi4-lite slave
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  localparam int PTR_W = $clog2(TRACE_DEPTH);

  logic [CTRL_W:0]       ctrl;
  bcpt_cmp_t             cmp [3];
  logic [DATA_W-1:0]     cmp_data [2];
  logic [2:0]            hit;
  logic [2:0]            armed;
  logic [PTR_W-1:0]      trc_idx;
  logic [LINE_W-1:0]     trc_mem [TRACE_DEPTH];
  logic [PTR_W-1:0]      wptr;
  logic                  wrapped;
  logic                  open;
  logic [1:0]            inc_cnt;
  logic [LINE_W-1:0]     open_line;
  logic [ADDR_W-1:INC_W] base_hi;
  logic                  have_last;
  logic [ADDR_W-1:0]     last_pc;
  logic [7:0]            aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  aw_held;
  logic                  w_held;
  logic                  wr_go;
  logic [31:0]           next_rdata;
  logic                  next_rerr;
  logic                  inhibit;
  logic [2:0]            next_match;
  logic                  in_range;
  logic                  trc_ev;
  logic                  trc_clear;

  // forced match: exact address plus optional direction/size
  function automatic logic forced_hit(bcpt_cmp_t c, bcpt_cpu_t b,
                                      logic sized);
    logic ok;
    ok = c.enable && !c.tag_enable && b.valid
         && (b.addr == c.addr);
    if (c.direction_compare_enable)
      ok = ok && (b.rnw == c.direction_select);
    if (sized && c.size_compare_enable)
      ok = ok && (b.word == c.access_size_select);
    return ok;
  endfunction : forced_hit

  function automatic logic [31:0] cmp_word(bcpt_cmp_t c);
    return {{(32 - $bits(bcpt_cmp_t)){1'b0}}, c};
  endfunction : cmp_word

  // comparator matching
  assign inhibit = BACKGROUND_DEBUG_MODE || BDM_ACCESS;
  assign in_range = CPU_BUS.valid && cmp[0].enable
                    && (CPU_BUS.addr >= cmp[0].addr)
                    && (CPU_BUS.addr <= cmp[1].addr);

  always_comb begin
    next_match = 3'h0;
    // each access judged on its own; earlier matches never revisited
    for (int i = 0; i < 2; i++) begin
      next_match[i] = forced_hit(cmp[i], CPU_BUS, 1'b1)
                      && (!cmp[i].data_compare_enable
                          || CPU_BUS.data == cmp_data[i]);
    end
    next_match[2] = forced_hit(cmp[2], CPU_BUS, 1'b0);
    for (int i = 0; i < 3; i++) begin
      // tagged: only address; fires when instruction executes
      if (cmp[i].enable && cmp[i].tag_enable) begin
        next_match[i] = armed[i] && CPU_EXEC.valid
                        && (CPU_EXEC.pc == cmp[i].addr);
      end
    end
    if (ctrl[CTRL_RANGE_EN]) begin
      next_match[0] = cmp[0].enable && CPU_BUS.valid
                      && (in_range ^ ctrl[CTRL_RANGE_OUT]);
      next_match[1] = 1'b0;
    end
    if (inhibit) begin
      next_match = 3'h0;
    end
  end

  // sequencer transition request, one cycle per match
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      MATCH <= 3'h0;
    end else begin
      MATCH <= next_match;
    end
  end

  // opcode tracking: armed at fetch, consumed at execution
  // debug activity drops every pending tag
  always_ff @(posedge CLOCK) begin
    if (RST || inhibit) begin
      armed <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!cmp[i].enable || !cmp[i].tag_enable) begin
          armed[i] <= 1'b0;
        end else if (CPU_BUS.valid && CPU_BUS.fetch
                     && CPU_BUS.addr == cmp[i].addr) begin
          armed[i] <= 1'b1;
        end else if (next_match[i]) begin
          armed[i] <= 1'b0;
        end
      end
    end
  end

  // sticky hit flags; a new hit beats a clear in the same cycle
  // cleared by writing ones through byte lane two of status
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      hit <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (next_match[i]) begin
          hit[i] <= 1'b1;
        end else if (wr_go && aw_addr == OFS_STATUS
                     && w_strb[STAT_HIT_LO / 8]
                     && w_data[STAT_HIT_LO + i]) begin
          hit[i] <= 1'b0;
        end
      end
    end
  end

  // trace capture
  // a clear in the same cycle as an event drops the event
  assign trc_clear = wr_go && aw_addr == OFS_CTRL && w_strb[0]
                     && w_data[CTRL_CLEAR];
  assign trc_ev = ctrl[CTRL_TRACE_EN] && CPU_EXEC.valid
                  && !(ctrl[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_SINGLE_LOOP_TRACE_MODE
                       && have_last && last_pc == CPU_EXEC.pc);

  always_ff @(posedge CLOCK) begin
    if (RST || trc_clear) begin
      wptr      <= '0;
      wrapped   <= 1'b0;
      open      <= 1'b0;
      inc_cnt   <= 2'h0;
      open_line <= '0;
      base_hi   <= '0;
      have_last <= 1'b0;
      last_pc   <= '0;
    end else if (trc_ev) begin
      have_last <= 1'b1;
      last_pc   <= CPU_EXEC.pc;
      if (ctrl[CTRL_MODE_HI:CTRL_MODE_LO] != MODE_PCONLY) begin
        // pc bit 16 lands in the high field low bit
        trc_mem[wptr] <= {{(LINE_W - 17){1'b0}},
                          CPU_EXEC.pc[16], CPU_EXEC.pc[15:0]};
        wptr <= wptr + 1'b1;
        wrapped <= wrapped || (wptr == PTR_W'(TRACE_DEPTH - 1));
      end else if ((!open && wptr == '0)
                   || CPU_EXEC.pc[ADDR_W-1:INC_W] != base_hi) begin
        trc_mem[wptr] <= {CODE_BASE, CPU_EXEC.pc};
        base_hi <= CPU_EXEC.pc[ADDR_W-1:INC_W];
        wptr    <= wptr + 1'b1;
        wrapped <= wrapped || (wptr == PTR_W'(TRACE_DEPTH - 1));
        open    <= 1'b0;
      end else if (open) begin
        // open line rewritten in place so no cycle writes twice
        if (inc_cnt == 2'h1) begin
          open_line <= {CODE_INC2, {INC_W{1'b0}},
                        CPU_EXEC.pc[INC_W-1:0],
                        open_line[INC_W-1:0]};
          trc_mem[wptr - 1'b1] <= {CODE_INC2, {INC_W{1'b0}},
                                   CPU_EXEC.pc[INC_W-1:0],
                                   open_line[INC_W-1:0]};
          inc_cnt <= 2'h2;
        end else begin
          trc_mem[wptr - 1'b1] <= {CODE_INC3,
                                   CPU_EXEC.pc[INC_W-1:0],
                                   open_line[2*INC_W-1:0]};
          inc_cnt <= 2'h3;
          open    <= 1'b0;
        end
      end else begin
        // offset from the 64-address block base
        open_line <= {CODE_INC1, {(2*INC_W){1'b0}},
                      CPU_EXEC.pc[INC_W-1:0]};
        trc_mem[wptr] <= {CODE_INC1, {(2*INC_W){1'b0}},
                          CPU_EXEC.pc[INC_W-1:0]};
        inc_cnt <= 2'h1;
        open    <= 1'b1;
        wptr    <= wptr + 1'b1;
        wrapped <= wrapped || (wptr == PTR_W'(TRACE_DEPTH - 1));
      end
    end
  end

  // axi write channel: address and data accepted in either order
  assign wr_go = aw_held && w_held && !S_AXI_BVALID;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
    end else begin
      // readies stay low until the response is gone: one write at a time
      S_AXI_AWREADY <= !aw_held && !S_AXI_BVALID
                       && !(S_AXI_AWVALID && S_AXI_AWREADY);
      S_AXI_WREADY  <= !w_held && !S_AXI_BVALID
                       && !(S_AXI_WVALID && S_AXI_WREADY);
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        unique case (aw_addr)
          OFS_CTRL, OFS_CMP_A, OFS_CMP_B, OFS_CMP_C, OFS_DATA_A,
          OFS_DATA_B, OFS_STATUS, OFS_TRC_IDX, OFS_TRC_DATA:
            S_AXI_BRESP <= RESP_OKAY;
          default:
            S_AXI_BRESP <= RESP_SLVERR;
        endcase
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // software registers; byte lanes honoured
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctrl     <= '0;
      cmp      <= '{default: '0};
      cmp_data <= '{default: '0};
      trc_idx  <= '0;
    end else if (wr_go) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb[b]) begin
          unique case (aw_addr)
            OFS_CTRL:
              if (b == 0) ctrl <= w_data[CTRL_W:0];
            OFS_CMP_A, OFS_CMP_B, OFS_CMP_C:
              for (int k = 0; k < 8; k++) begin
                if (b * 8 + k < $bits(bcpt_cmp_t))
                  cmp[aw_addr[3:2] - 2'h1][b * 8 + k] <= w_data[b * 8 + k];
              end
            OFS_DATA_A, OFS_DATA_B:
              if (b < 2)
                cmp_data[aw_addr[2]][b * 8 +: 8] <= w_data[b * 8 +: 8];
            OFS_TRC_IDX:
              if (b == 0) trc_idx <= w_data[PTR_W-1:0];
            default: ;
          endcase
        end
      end
      // clear is an action, not a stored setting
      ctrl[CTRL_CLEAR] <= 1'b0;
    end
  end

  // axi read channel: answer one cycle after address taken
  always_comb begin
    next_rdata = 32'h0;
    next_rerr  = 1'b0;
    unique case (S_AXI_ARADDR)
      OFS_CTRL:     next_rdata[CTRL_W:0] = ctrl;
      OFS_CMP_A:    next_rdata = cmp_word(cmp[0]);
      OFS_CMP_B:    next_rdata = cmp_word(cmp[1]);
      OFS_CMP_C:    next_rdata = cmp_word(cmp[2]);
      OFS_DATA_A:   next_rdata[DATA_W-1:0] = cmp_data[0];
      OFS_DATA_B:   next_rdata[DATA_W-1:0] = cmp_data[1];
      OFS_STATUS: begin
        // after a wrap the write pointer marks the oldest line
        next_rdata[PTR_W-1:0] = wptr;
        next_rdata[STAT_HIT_HI:STAT_HIT_LO] = hit;
        next_rdata[STAT_WRAP] = wrapped;
      end
      OFS_TRC_IDX:  next_rdata[PTR_W-1:0] = trc_idx;
      OFS_TRC_DATA: next_rdata[LINE_W-1:0] = trc_mem[trc_idx];
      default:      next_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= RESP_OKAY;
    // one read at a time: arready drops as the address is taken
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= next_rdata;
      S_AXI_RRESP   <= next_rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end else if (!S_AXI_RVALID) begin
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule : bcpt_top

// >>> inc/bcpt_pkg.sv
package bcpt_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int INC_W  = 6;
  localparam int LINE_W = 2 + 3 * INC_W;
  localparam int TRACE_DEPTH_DEF = 64;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CMP_A    = 8'h04;
  localparam logic [7:0] OFS_CMP_B    = 8'h08;
  localparam logic [7:0] OFS_CMP_C    = 8'h0c;
  localparam logic [7:0] OFS_DATA_A   = 8'h10;
  localparam logic [7:0] OFS_DATA_B   = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_TRC_IDX  = 8'h1c;
  localparam logic [7:0] OFS_TRC_DATA = 8'h20;

  // control register fields
  localparam int CTRL_TRACE_EN  = 0;
  localparam int CTRL_MODE_LO   = 1;
  localparam int CTRL_MODE_HI   = 2;
  localparam int CTRL_RANGE_EN  = 3;
  localparam int CTRL_RANGE_OUT = 4;
  localparam int CTRL_CLEAR     = 5;
  localparam int CTRL_W         = 5;

  // status register fields
  localparam int STAT_HIT_LO = 16;
  localparam int STAT_HIT_HI = 18;
  localparam int STAT_WRAP   = 19;

  // trace modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SINGLE_LOOP_TRACE_MODE  = 2'h1;
  localparam logic [1:0] MODE_PCONLY = 2'h2;

  // row content codes
  localparam logic [1:0] CODE_BASE = 2'h0;
  localparam logic [1:0] CODE_INC1 = 2'h1;
  localparam logic [1:0] CODE_INC2 = 2'h2;
  localparam logic [1:0] CODE_INC3 = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic              valid;
    logic              rnw;
    logic              word;
    logic              fetch;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bcpt_cpu_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] pc;
  } bcpt_exec_t;

  // comparator register image, bit 0 upward is addr
  typedef struct packed {
    logic              data_compare_enable;
    logic              access_size_select;
    logic              size_compare_enable;
    logic              direction_select;
    logic              direction_compare_enable;
    logic              tag_enable;
    logic              enable;
    logic [ADDR_W-1:0] addr;
  } bcpt_cmp_t;

endpackage : bcpt_pkg

// >>> tb/bcpt_cpu_model.sv
`timescale 1ns/100ps
module bcpt_cpu_model
  import bcpt_pkg::*;
(
  // clock
  input  wire logic CLOCK,
  // core buses
  output bcpt_cpu_t  CPU_BUS,
  output bcpt_exec_t CPU_EXEC
);
  initial begin
    CPU_BUS = '0;
    CPU_EXEC = '0;
  end

  // one access, c is {rnw, word, fetch}; idle bus never repeats the address
  task access(input logic [17:0] a, input logic [2:0] c);
    @(posedge CLOCK);
    CPU_BUS <= {1'b1, c, a, 16'h5a5a};
    @(posedge CLOCK);
    CPU_BUS <= {1'b0, ~c, ~a, 16'ha5a5};
  endtask : access

  // instruction reaching the execute stage
  task exec(input logic [17:0] pc);
    @(posedge CLOCK);
    CPU_EXEC <= {1'b1, pc};
    @(posedge CLOCK);
    CPU_EXEC <= {1'b0, ~pc};
  endtask : exec
endmodule : bcpt_cpu_model

// >>> tb/bcpt_assertions.sv
`timescale 1ns/100ps
module bcpt_assertions
  import bcpt_pkg::*;
#(
  parameter int TRACE_DEPTH = TRACE_DEPTH_DEF
) (
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        RST,
  // cpu side
  input wire bcpt_cpu_t   CPU_BUS,
  input wire bcpt_exec_t  CPU_EXEC,
  input wire logic        BACKGROUND_DEBUG_MODE,
  input wire logic        BDM_ACCESS,
  input wire logic [2:0]  MATCH,
  // register bus
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);

  bdm_quiet_a: assert property (
    (BACKGROUND_DEBUG_MODE || BDM_ACCESS) |=> MATCH == 3'h0)
    else $error("match while debug access active");
  match_cause_a: assert property (
    MATCH != 3'h0 |-> $past(CPU_BUS.valid) || $past(CPU_EXEC.valid))
    else $error("match without a core access");
  reset_clear_a: assert property (
    $fell(RST) |-> MATCH == 3'h0 && !S_AXI_BVALID && !S_AXI_RVALID)
    else $error("outputs not idle after reset");
  bresp_hold_a: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  rdata_hold_a: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  read_answer_a: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |-> ##1 S_AXI_RVALID)
    else $error("read answer late");
  write_answer_a: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |-> ##[1:2] S_AXI_BVALID)
    else $error("write answer late");
  write_block_a: assert property (
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write accepted while response pending");
  read_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read accepted while data pending");
endmodule : bcpt_assertions

bind bcpt_top bcpt_assertions #(.TRACE_DEPTH(TRACE_DEPTH)) u_chk (
  .CLOCK(CLOCK), .RST(RST), .CPU_BUS(CPU_BUS), .CPU_EXEC(CPU_EXEC),
  .BACKGROUND_DEBUG_MODE(BACKGROUND_DEBUG_MODE), .BDM_ACCESS(BDM_ACCESS),
  .MATCH(MATCH), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY));

// >>> tb/bcpt_top_tb_top.sv
`timescale 1ns/100ps
module bcpt_top_tb_top
  import bcpt_pkg::*;
;
  logic        clock = 0;
  logic        rst;
  logic        bgd;
  logic        dbg_acc;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awvalid;
  logic        wvalid;
  logic        bready;
  logic        arvalid;
  logic        rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  match;
  bcpt_cpu_t   cpu_bus;
  bcpt_exec_t  cpu_exec;
  int          err_total = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [17:0] pcs [6] = '{18'h10040, 18'h10041, 18'h10042, 18'h10043,
                           18'h10045, 18'h10080};
  logic [31:0] rows [4] = '{32'h10040, 32'hc3081, 32'h40005, 32'h10080};

  always #10 clock = ~clock;

  bcpt_cpu_model u_cpu (.CLOCK(clock), .CPU_BUS(cpu_bus),
    .CPU_EXEC(cpu_exec));

  // small depth so the rollover is reached quickly
  bcpt_top #(.TRACE_DEPTH(8)) i_dut (
    .CLOCK(clock), .RST(rst), .CPU_BUS(cpu_bus), .CPU_EXEC(cpu_exec),
    .BACKGROUND_DEBUG_MODE(bgd), .BDM_ACCESS(dbg_acc), .MATCH(match),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));

  task final_report;
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      final_report();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // address and data go out together, each released once taken
  task wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    chk({30'h0, bresp}, {30'h0, r});
  endtask : wrc

  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
           input logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    chk({30'h0, rresp}, {30'h0, r});
    chk(rdata & m, e);
  endtask : rdc

  // c is {rnw, word, fetch}; match is registered one cycle after the access
  task hit(input logic [17:0] a, input logic [2:0] c, input logic [2:0] e);
    u_cpu.access(a, c);
    #1;
    chk({29'h0, match}, {29'h0, e});
  endtask : hit

  function automatic logic [31:0] cmpw(input logic [6:0] f,
                                        input logic [17:0] a);
    return {7'h0, f, a};
  endfunction : cmpw

  task trc(input logic [5:0] i, input logic [31:0] e);
    wrc(OFS_TRC_IDX, {26'h0, i}, RESP_OKAY);
    rdc(OFS_TRC_DATA, 32'hfffff, e, RESP_OKAY);
  endtask : trc

  initial begin
    rst     <= 1'b1;
    bgd     <= 1'b0;
    dbg_acc <= 1'b0;
    awaddr  <= 8'h00;
    araddr  <= 8'h00;
    wdata   <= 32'h0;
    wstrb   <= 4'hf;
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b0;
    arvalid <= 1'b0;
    rready  <= 1'b0;
    repeat (5) @(posedge clock);
    rst <= 0;
    rdc(OFS_CTRL, '1, 32'h0, RESP_OKAY);
    rdc(OFS_CMP_A, '1, 32'h0, RESP_OKAY);
    rdc(OFS_STATUS, '1, 32'h0, RESP_OKAY);
    rdc(8'h40, '1, 32'h0, RESP_SLVERR);
    wrc(8'h40, 32'h1, RESP_SLVERR);
    wrc(OFS_CMP_A, cmpw(7'h01, 18'h01234), RESP_OKAY);
    hit(18'h01234, 3'h4, 3'h1);
    hit(18'h01235, 3'h4, 3'h0);
    hit(18'h01234, 3'h7, 3'h1);
    wrc(OFS_DATA_A, 32'h5a5a, RESP_OKAY);
    wrc(OFS_CMP_A, cmpw(7'h41, 18'h01234), RESP_OKAY);
    hit(18'h01234, 3'h4, 3'h1);
    wrc(OFS_DATA_A, 32'h1234, RESP_OKAY);
    hit(18'h01234, 3'h4, 3'h0);
    wrc(OFS_CMP_B, cmpw(7'h0d, 18'h02000), RESP_OKAY);
    hit(18'h02000, 3'h0, 3'h0);
    hit(18'h02000, 3'h4, 3'h2);
    wrc(OFS_CMP_B, cmpw(7'h31, 18'h02000), RESP_OKAY);
    hit(18'h02000, 3'h4, 3'h0);
    hit(18'h02000, 3'h2, 3'h2);
    // size bits set on the third comparator must have no effect
    wrc(OFS_CMP_C, cmpw(7'h3d, 18'h03001), RESP_OKAY);
    hit(18'h03001, 3'h4, 3'h4);
    hit(18'h03001, 3'h0, 3'h0);
    hit(18'h03000, 3'h6, 3'h0);
    @(posedge clock);
    bgd <= 1;
    hit(18'h03001, 3'h4, 3'h0);
    @(posedge clock);
    bgd <= 0;
    dbg_acc <= 1;
    hit(18'h03001, 3'h4, 3'h0);
    @(posedge clock);
    dbg_acc <= 0;
    hit(18'h03001, 3'h4, 3'h4);
    // tagged: write-only direction set, yet a read fetch arms it
    wrc(OFS_CMP_A, cmpw(7'h07, 18'h04000), RESP_OKAY);
    hit(18'h04000, 3'h5, 3'h0);
    u_cpu.exec(18'h04000);
    #1;
    chk({29'h0, match}, 32'h1);
    wrc(OFS_CMP_A, cmpw(7'h01, 18'h00100), RESP_OKAY);
    wrc(OFS_CMP_B, cmpw(7'h01, 18'h001ff), RESP_OKAY);
    wrc(OFS_CMP_C, 32'h0, RESP_OKAY);
    wrc(OFS_CTRL, 32'h08, RESP_OKAY);
    hit(18'h00150, 3'h4, 3'h1);
    hit(18'h001ff, 3'h4, 3'h1);
    hit(18'h00200, 3'h4, 3'h0);
    wrc(OFS_CTRL, 32'h18, RESP_OKAY);
    hit(18'h00150, 3'h4, 3'h0);
    hit(18'h00300, 3'h4, 3'h1);
    rdc(OFS_STATUS, 32'h70000, 32'h70000, RESP_OKAY);
    wstrb <= 4'h3;
    wrc(OFS_STATUS, 32'h70000, RESP_OKAY);
    rdc(OFS_STATUS, 32'h70000, 32'h70000, RESP_OKAY);
    wstrb <= 4'hf;
    wrc(OFS_STATUS, 32'h70000, RESP_OKAY);
    rdc(OFS_STATUS, 32'h70000, 32'h0, RESP_OKAY);
    wrc(OFS_CTRL, 32'h20, RESP_OKAY);
    wrc(OFS_CTRL, 32'h01, RESP_OKAY);
    u_cpu.exec(18'h3abcd);
    trc(6'h0, 32'h1abcd);
    wrc(OFS_CTRL, 32'h20, RESP_OKAY);
    wrc(OFS_CTRL, 32'h03, RESP_OKAY);
    u_cpu.exec(18'h00010);
    u_cpu.exec(18'h00010);
    u_cpu.exec(18'h00011);
    trc(6'h1, 32'h00011);
    rdc(OFS_STATUS, 32'h3f, 32'h2, RESP_OKAY);
    wrc(OFS_CTRL, 32'h20, RESP_OKAY);
    wrc(OFS_CTRL, 32'h05, RESP_OKAY);
    foreach (pcs[i]) u_cpu.exec(pcs[i]);
    for (int i = 0; i < 4; i++) trc(6'(i), rows[i]);
    rdc(OFS_STATUS, 32'h3f, 32'h4, RESP_OKAY);
    wrc(OFS_CTRL, 32'h20, RESP_OKAY);
    wrc(OFS_CTRL, 32'h05, RESP_OKAY);
    for (int i = 0; i < 8; i++) u_cpu.exec(18'(i * 64));
    u_cpu.exec(18'h001c1);
    trc(6'h0, 32'h001c1);
    trc(6'h1, 32'h00040);
    rdc(OFS_STATUS, 32'h8003f, 32'h80001, RESP_OKAY);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rdc(OFS_CMP_A, '1, 32'h0, RESP_OKAY);
    rdc(OFS_STATUS, '1, 32'h0, RESP_OKAY);
    final_report();
  end
endmodule : bcpt_top_tb_top
